/* File: include/tad_consts.vh */
// Constants for the temperature alarm and digital line readout block
`ifndef TAD_CONSTS_VH
`define TAD_CONSTS_VH
`define TAD_NLINE        8
`define TAD_OFS_DIR      12'h000
`define TAD_OFS_OUT      12'h004
`define TAD_OFS_PIN      12'h008
`define TAD_OFS_ALMCFG   12'h00C
`define TAD_OFS_THR0     12'h010
`define TAD_OFS_THR1     12'h014
`define TAD_OFS_THR2     12'h018
`define TAD_OFS_THR3     12'h01C
`define TAD_OFS_THR4     12'h020
`define TAD_OFS_THR5     12'h024
`define TAD_OFS_THR6     12'h028
`define TAD_OFS_THRLAST  12'h02C
`define TAD_OFS_STAT     12'h030
`define TAD_OFS_MASK     12'h034
`define TAD_OFS_FAULT    12'h038
`define TAD_OFS_RSEL     12'h03C
`define TAD_OFS_RES      12'h040
`define TAD_OFS_NVCMD    12'h044
`define TAD_OFS_CJC      12'h048
`define TAD_OFS_CHAN     12'h04C
`define TAD_OFS_FMT      12'h050
`define TAD_OFS_IEXC     12'h054
`define TAD_OFS_LIN      12'h058
`define TAD_OFS_TCOEF    12'h05C
`define TAD_OFS_TCOEF1   12'h060
`define TAD_OFS_TCOEF2   12'h064
`define TAD_RES_DIR      8'h00
`define TAD_RES_IEXC     32'h3A83126F
`define TAD_STAT_ALM     0
`define TAD_STAT_FLT     8
`define TAD_STAT_SMP     16
`define TAD_ALM_EN       0
`define TAD_ALM_POL      8
`define TAD_ALM_ABOVE    16
`define TAD_ALM_LINE     24
`define TAD_NV_SAVE      32'h00000001
`endif

/* File: design/tad_readout.v */
// Digital lines, temperature alarms, sensor fault flags and result selection
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tad_consts.vh"
module tad_readout
(
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         irq,
   input  wire [7:0]  linePinIn,
   output reg  [7:0]  lineOut,
   output reg  [7:0]  lineOe,
   input  wire        sampleValid,
   input  wire [2:0]  sampleChan,
   input  wire [31:0] sampleTemp,
   input  wire [31:0] sampleVolt,
   input  wire [31:0] sampleRes,
   input  wire        sampleOpen,
   input  wire [31:0] cjcLeft,
   input  wire [31:0] cjcRight,
   input  wire [31:0] nvAlmCfg,
   input  wire [255:0] nvThr,
   output reg         nvSave,
   output reg  [31:0] cjcAvg,
   output reg  [31:0] resultData,
   output reg         resultValid,
   output reg  [2:0]  resultChan,
   output reg  [31:0] iexcStored,
   output reg  [1:0]  rtdSet,
   output reg  [95:0] thermCoef,
   output reg  [2:0]  nextChan
);
   localparam ST_LOAD = 2'b01;
   localparam ST_RUN  = 2'b10;

   reg  [1:0]   state;
   reg  [7:0]   dirSw;
   reg  [7:0]   outSw;
   reg  [31:0]  almCfg;
   reg  [31:0]  almLive;
   reg  [255:0] thr;
   reg  [7:0]   almLines;
   reg  [7:0]   almAct;
   reg  [7:0]   fault;
   reg  [23:0]  stat;
   reg  [23:0]  mask;
   reg  [7:0]   fmtSel;
   reg  [23:0]  next_stat;
   reg  [31:0]  rdMux;
   wire         apbAcc = psel & penable;
   wire         wrEn = apbAcc & pwrite;
   wire         rdEn = apbAcc & ~pwrite;
   wire         apbSetup = psel & ~penable;
   wire [63:0]  cjcSum = {32'h00000000, cjcLeft} + {32'h00000000, cjcRight};
   integer      k;
   integer      j;

   // Settle pins and alarm levels once, then run; direction only fixed here
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_LOAD;
         almLive <= 32'h00000000;
         thr <= {256{1'b0}};
         almLines <= 8'h00;
      end
      else
      begin
         case (state)
            ST_LOAD:
            begin
               almLive <= nvAlmCfg;
               thr <= nvThr;
               almLines <= nvAlmCfg[`TAD_ALM_LINE+7:`TAD_ALM_LINE];
               state <= ST_RUN;
            end
            ST_RUN:
            begin
               state <= ST_RUN;
            end
            default:
            begin
               state <= ST_LOAD;
            end
         endcase
      end
   end

   // Alarm evaluation per channel; the channel's own sample decides
   genvar g;
   generate
      for (g = 0; g < `TAD_NLINE; g = g + 1)
      begin : almGen
         wire hit = sampleValid && sampleChan == g && !sampleOpen;
         wire above = $signed(sampleTemp) > $signed(thr[g*32+31:g*32]);
         always @(posedge clk_sys or negedge nrst)
         begin
            if (!nrst)
               almAct[g] <= 1'b0;
            else if (!almLive[`TAD_ALM_EN+g])
               almAct[g] <= 1'b0;
            else if (hit)
               almAct[g] <= almLive[`TAD_ALM_ABOVE+g] ? above : ~above;
         end
      end
   endgenerate

   // Lines and status
   always @*
   begin
      next_stat = stat;
      // Clear only what the read reported, so an event during the access is kept
      if (rdEn && paddr == `TAD_OFS_STAT)
         next_stat = stat & ~prdata[23:0];
      for (k = 0; k < `TAD_NLINE; k = k + 1)
      begin
         if (almAct[k])
            next_stat[`TAD_STAT_ALM+k] = 1'b1;
         if (sampleValid && sampleChan == k && sampleOpen)
            next_stat[`TAD_STAT_FLT+k] = 1'b1;
         if (sampleValid && sampleChan == k)
            next_stat[`TAD_STAT_SMP+k] = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         lineOut <= 8'h00;
         lineOe <= 8'h00;
         stat <= 24'h000000;
         fault <= 8'h00;
         irq <= 1'b0;
         resultData <= 32'h00000000;
         resultValid <= 1'b0;
         resultChan <= 3'b000;
         nextChan <= 3'b000;
         cjcAvg <= 32'h00000000;
      end
      else
      begin
         for (j = 0; j < `TAD_NLINE; j = j + 1)
         begin
            if (almLines[j] && state == ST_RUN)
            begin
               lineOe[j] <= 1'b1;
               // Active drives polarity, idle drives the opposite
               lineOut[j] <= almAct[j] ? almLive[`TAD_ALM_POL+j]
                                       : ~almLive[`TAD_ALM_POL+j];
            end
            else
            begin
               lineOe[j] <= dirSw[j];
               lineOut[j] <= outSw[j];
            end
            if (sampleValid && sampleChan == j)
               fault[j] <= sampleOpen;
         end
         stat <= next_stat;
         irq <= |(next_stat & mask);
         // Sequence advances regardless of faults
         if (sampleValid)
            nextChan <= sampleChan + 3'b001;
         resultValid <= sampleValid;
         resultChan <= sampleChan;
         if (sampleValid)
            resultData <= fmtSel[sampleChan] ? sampleTemp : sampleVolt;
         cjcAvg <= cjcSum[32:1];
      end
   end

   // APB slave, zero wait states
   always @*
   begin
      rdMux = 32'h00000000;
      if (paddr == `TAD_OFS_DIR)
         rdMux = {24'h000000, dirSw};
      else if (paddr == `TAD_OFS_OUT)
         rdMux = {24'h000000, outSw};
      else if (paddr == `TAD_OFS_PIN)
         rdMux = {24'h000000, linePinIn};
      else if (paddr == `TAD_OFS_ALMCFG)
         rdMux = almCfg;
      else if (paddr == `TAD_OFS_THR0)
         rdMux = thr[31:0];
      else if (paddr == `TAD_OFS_THR1)
         rdMux = thr[63:32];
      else if (paddr == `TAD_OFS_THR2)
         rdMux = thr[95:64];
      else if (paddr == `TAD_OFS_THR3)
         rdMux = thr[127:96];
      else if (paddr == `TAD_OFS_THR4)
         rdMux = thr[159:128];
      else if (paddr == `TAD_OFS_THR5)
         rdMux = thr[191:160];
      else if (paddr == `TAD_OFS_THR6)
         rdMux = thr[223:192];
      else if (paddr == `TAD_OFS_THRLAST)
         rdMux = thr[255:224];
      else if (paddr == `TAD_OFS_STAT)
         rdMux = {8'h00, stat};
      else if (paddr == `TAD_OFS_MASK)
         rdMux = {8'h00, mask};
      else if (paddr == `TAD_OFS_FAULT)
         rdMux = {24'h000000, fault};
      else if (paddr == `TAD_OFS_RSEL)
         rdMux = {24'h000000, fmtSel};
      else if (paddr == `TAD_OFS_RES)
         rdMux = sampleRes;
      else if (paddr == `TAD_OFS_CJC)
         rdMux = cjcAvg;
      else if (paddr == `TAD_OFS_CHAN)
         rdMux = {29'h00000000, nextChan};
      else if (paddr == `TAD_OFS_IEXC)
         rdMux = iexcStored;
      else if (paddr == `TAD_OFS_LIN)
         rdMux = {30'h00000000, rtdSet};
      else if (paddr == `TAD_OFS_TCOEF)
         rdMux = thermCoef[31:0];
      else if (paddr == `TAD_OFS_TCOEF1)
         rdMux = thermCoef[63:32];
      else if (paddr == `TAD_OFS_TCOEF2)
         rdMux = thermCoef[95:64];
   end

   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         dirSw <= `TAD_RES_DIR;
         outSw <= 8'h00;
         almCfg <= 32'h00000000;
         mask <= 24'h000000;
         fmtSel <= 8'h00;
         iexcStored <= `TAD_RES_IEXC;
         rtdSet <= 2'b00;
         thermCoef <= {96{1'b0}};
         nvSave <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         nvSave <= 1'b0;
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         // Capture at setup so read data stands with pready in the access phase
         if (apbSetup && !pwrite)
            prdata <= rdMux;
         if (wrEn)
         begin
            if (paddr == `TAD_OFS_DIR)
               dirSw <= pwdata[7:0];
            else if (paddr == `TAD_OFS_OUT)
               outSw <= pwdata[7:0];
            else if (paddr == `TAD_OFS_ALMCFG)
               almCfg <= pwdata;
            else if (paddr == `TAD_OFS_MASK)
               mask <= pwdata[23:0];
            else if (paddr == `TAD_OFS_RSEL)
               fmtSel <= pwdata[7:0];
            else if (paddr == `TAD_OFS_NVCMD)
               nvSave <= pwdata == `TAD_NV_SAVE;
            else if (paddr == `TAD_OFS_IEXC)
               iexcStored <= pwdata;
            else if (paddr == `TAD_OFS_LIN)
               rtdSet <= pwdata[1:0];
            else if (paddr == `TAD_OFS_TCOEF)
               thermCoef[31:0] <= pwdata;
            else if (paddr == `TAD_OFS_TCOEF1)
               thermCoef[63:32] <= pwdata;
            else if (paddr == `TAD_OFS_TCOEF2)
               thermCoef[95:64] <= pwdata;
         end
      end
   end
endmodule

/* File: bench/tad_readout_sva.sv */
// Port assertions for the readout block
`timescale 1ns/1ps
`include "tad_consts.vh"
module tad_readout_sva
(
   input wire        clk_sys,
   input wire        nrst,
   input wire [11:0] paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   input wire [7:0]  lineOe,
   input wire        sampleValid,
   input wire [2:0]  sampleChan,
   input wire        sampleOpen,
   input wire        resultValid,
   input wire [2:0]  resultChan,
   input wire [31:0] cjcLeft,
   input wire [31:0] cjcRight,
   input wire [31:0] cjcAvg,
   input wire [31:0] nvAlmCfg,
   input wire        nvSave
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire        wr = psel && penable && pready && pwrite;
   wire [7:0]  alm = nvAlmCfg[31:24];
   wire [32:0] cjcSum = cjcLeft + cjcRight;
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("pready late");
   no_error_a: assert property (!pslverr) else $error("pslverr set");
   dir_write_a: assert property (wr && paddr == `TAD_OFS_DIR |-> ##2
      (lineOe & ~alm) == ($past(pwdata[7:0], 2) & ~alm)) else $error("dir not applied");
   alarm_dir_a: assert property ($past(nrst, 3) |-> (lineOe & alm) == alm)
      else $error("alarm line not output");
   cfg_keeps_a: assert property (wr && paddr == `TAD_OFS_ALMCFG |=> $stable(lineOe)[*2])
      else $error("direction moved");
   result_next_a: assert property (sampleValid |=> resultValid &&
      resultChan == $past(sampleChan)) else $error("result late");
   cjc_avg_a: assert property ($past(nrst) |-> cjcAvg == $past(cjcSum[32:1]))
      else $error("cjc average wrong");
   save_pulse_a: assert property (wr && paddr == `TAD_OFS_NVCMD && pwdata == 32'h1 |->
      ##[1:2] nvSave) else $error("no save pulse");
   cover property (wr && paddr == `TAD_OFS_DIR);
   cover property (sampleValid && sampleOpen);
   cover property (nvSave);
   cover property (sampleValid ##1 resultValid);
endmodule
bind tad_readout tad_readout_sva u_tad_readout_sva (.*);

/* File: bench/tad_far_side.sv */
// External digital line drivers with pull-ups
`timescale 1ns/1ps
module tad_far_side
(
   input  wire [7:0] lineOut,
   input  wire [7:0] lineOe,
   input  wire [7:0] extLevel,
   input  wire [7:0] extOe,
   output wire [7:0] linePinIn
);
   // Undriven pins float to the pull-up; contention is not modelled
   assign linePinIn = (lineOe & lineOut) | (~lineOe & ((extOe & extLevel) | ~extOe));
endmodule

/* File: bench/tb.sv */
// Register level test of the readout block
`timescale 1ns/1ps
`include "tad_consts.vh"
module tb;
   logic         clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic         sampleValid = 0, sampleOpen = 0;
   logic [11:0]  paddr = '0;
   logic [2:0]   sampleChan = '0;
   logic [31:0]  pwdata = '0, sampleTemp = '0, sampleVolt = '0, sampleRes = '0;
   logic [31:0]  cjcLeft = '0, cjcRight = '0, rd;
   logic [31:0]  nvAlmCfg = 32'h81010181;
   logic [255:0] nvThr = {32'h64, 192'h0, 32'h64};
   logic [7:0]   extLevel = '0, extOe = '0;
   wire  [31:0]  prdata, cjcAvg, resultData, iexcStored;
   wire          pready, pslverr, irq, nvSave, resultValid;
   wire  [7:0]   lineOut, lineOe, linePinIn;
   wire  [2:0]   resultChan, nextChan;
   wire  [1:0]   rtdSet;
   wire  [95:0]  thermCoef;
   int           failures = 0, compares = 0;
   tad_readout u_tad_readout (.*);
   tad_far_side u_tad_far_side (.*);
   always #25 clk_sys = ~clk_sys;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Holds the request until pready is seen at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      rd = prdata;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task smp(input logic [2:0] c, input logic [31:0] t, input logic o);
      @(posedge clk_sys);
      sampleValid <= 1'h1;
      sampleChan  <= c;
      sampleTemp  <= t;
      sampleVolt  <= ~t;
      sampleOpen  <= o;
      @(posedge clk_sys);
      sampleValid <= 1'h0;
      repeat (3) @(posedge clk_sys);
   endtask
   task stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk("oe", 32'h81, lineOe);
      chk("out", 32'h80, lineOut & 8'h81);
      apb(1, `TAD_OFS_ALMCFG, 32'h83010181);
      repeat (2) @(posedge clk_sys);
      chk("oe", 32'h81, lineOe);
      apb(1, `TAD_OFS_DIR, 32'h0F);
      repeat (2) @(posedge clk_sys);
      chk("oe", 32'h8F, lineOe);
      apb(1, `TAD_OFS_DIR, 32'h0);
      extOe <= 8'h7E;
      for (int i = 0; i < 2; i++)
      begin
         extLevel <= i ? 8'hFF : 8'h00;
         apb(0, `TAD_OFS_PIN, 0);
         chk("pin", i ? 32'h7E : 32'h0, rd & 32'h7E);
      end
      extOe <= 8'h00;
      apb(1, `TAD_OFS_MASK, 32'h1);
      apb(1, `TAD_OFS_RSEL, 32'h1);
      smp(0, 32'hC8, 0);
      chk("line", 32'h81, lineOut & 8'h81);
      chk("temp", 32'hC8, resultData);
      chk("irq", 32'h1, irq);
      // Open reading below threshold must not release the alarm
      smp(0, 32'h32, 1);
      chk("line", 32'h81, lineOut & 8'h81);
      chk("next", 32'h1, nextChan);
      apb(0, `TAD_OFS_STAT, 0);
      chk("stat", 32'h101, rd & 32'h101);
      apb(0, `TAD_OFS_FAULT, 0);
      chk("fault", 32'h01, rd);
      apb(1, `TAD_OFS_MASK, 32'h0);
      apb(0, `TAD_OFS_STAT, 0);
      chk("stat", 32'h1, rd & 32'h101);
      chk("irq", 32'h0, irq);
      smp(1, 32'h10, 0);
      chk("volt", 32'hFFFFFFEF, resultData);
      chk("next", 32'h2, nextChan);
      smp(7, 32'h32, 0);
      chk("line", 32'h01, lineOut & 8'h81);
      smp(0, 32'h32, 0);
      chk("line", 32'h00, lineOut & 8'h81);
      cjcLeft  <= 32'h10;
      cjcRight <= 32'h21;
      repeat (2) @(posedge clk_sys);
      chk("cjc", 32'h18, cjcAvg);
      apb(1, `TAD_OFS_IEXC, 32'h3F800000);
      for (int i = 0; i < 3; i++)
      begin
         apb(1, `TAD_OFS_LIN, i);
         @(posedge clk_sys);
         chk("lin", i, rtdSet);
      end
      chk("iexc", 32'h3F800000, iexcStored);
      sampleRes <= 32'h42C80000;
      apb(0, `TAD_OFS_RES, 0);
      chk("res", 32'h42C80000, rd);
      apb(1, `TAD_OFS_TCOEF, 32'h11111111);
      apb(1, `TAD_OFS_TCOEF1, 32'h22222222);
      apb(1, `TAD_OFS_TCOEF2, 32'h33333333);
      @(posedge clk_sys);
      chk("coef", 32'h11111111, thermCoef[31:0]);
      chk("coef", 32'h33333333, thermCoef[95:64]);
      apb(0, `TAD_OFS_TCOEF1, 0);
      chk("coef", 32'h22222222, rd);
      apb(0, `TAD_OFS_THR0, 0);
      chk("thr", 32'h64, rd);
      apb(0, `TAD_OFS_THRLAST, 0);
      chk("thr", 32'h64, rd);
      apb(1, `TAD_OFS_NVCMD, 32'h1);
      apb(0, 12'hFFC, 0);
      chk("unmapped", 32'h0, rd);
      stop_test;
   end
   initial
   begin
      #200000;
      failures++;
      stop_test;
   end
endmodule
